// file: shared/dcp_pkg.sv
// Shared constants and types for the dual-core power and reset controller
package dcp_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_MHZ = 200;
  localparam real LF_CLK_KHZ = 32.768;
  localparam int LF_CLK_HZ = int'(LF_CLK_KHZ * 1000.0);
  localparam int RST_HOLD_NS = 100;
  localparam int RST_HOLD_CYC_I = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] RST_HOLD_CYC = 8'(RST_HOLD_CYC_I);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam int RTC_W = 24;
  localparam int ACC_W = 29;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(LF_CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);
  localparam int GPIO_N = 48;
  localparam int GPIO_SEL_W = 6;
  localparam int RAM_SECT_N = 8;
  localparam int PERIPH_N = 4;
  localparam int CAUSE_N = 6;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_BROWNOUT = 2;
  localparam int CAUSE_WAKE = 3;
  localparam int CAUSE_SOFT = 4;
  localparam int CAUSE_WDOG = 5;
  localparam logic [CAUSE_N-1:0] CAUSE_RESET_VAL = 6'h01;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_RUN = 2'h1;
  localparam logic [1:0] MODE_IDLE = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_RUN = 4'h2,
    ST_IDLE = 4'h4,
    ST_OFF = 4'h8
  } dcp_state_e;
endpackage

// file: hw/dcp_rtc_counter.sv
// Real-time counter ticking at the low-frequency clock rate
`timescale 1ns/100ps
module dcp_rtc_counter
  import dcp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic run_in,
  input wire logic [RTC_W-1:0] compare_in,
  output logic tick_out,
  output logic [RTC_W-1:0] count_out,
  output logic compare_event_out,
  output logic overflow_event_out
);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] acc_d;
  logic lf_tick;
  logic [RTC_W-1:0] count_d;

  // RULE_19 - fractional divider to low-frequency rate
  assign acc_sum = acc_q + ACC_STEP;
  assign lf_tick = run_in && (acc_sum >= ACC_WRAP);
  assign acc_d = !run_in ? acc_q : (lf_tick ? acc_sum - ACC_WRAP : acc_sum);
  assign count_d = lf_tick ? count_out + RTC_W'(1) : count_out;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_q <= '0;
      tick_out <= 1'b0;
      count_out <= '0;
      compare_event_out <= 1'b0;
      overflow_event_out <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_out <= lf_tick;
      count_out <= count_d;
      compare_event_out <= lf_tick && (count_d == compare_in);
      overflow_event_out <= lf_tick && (count_d == '0);
    end
  end
endmodule

// file: hw/dcp_power_ctrl.sv
// Power-mode and reset sequencer for the application and network cores
//
// Contract
// RULE_01 - After power-on reset the device enters the run state.
// RULE_02 - Comparator rise, NFC field or USB supply arrival leave deep-off.
// RULE_03 - Counter event, radio event or NFC field return idle to run.
// RULE_04 - Idle has constant-latency and low-power sub-modes.
// RULE_05 - Deep-off powers down core functions and aborts all tasks.
// RULE_06 - Any selected general-purpose pin can trigger deep-off.
// RULE_07 - Brownout resets the whole system; network core stays held off.
// RULE_08 - Saving settings to non-volatile memory is not allowed under brownout.
// RULE_09 - Power-on starts only the application core; network core held off.
// RULE_10 - Pin reset restarts like power-on, network core held off.
// RULE_11 - Leaving deep-off resets the system with network core held off.
// RULE_12 - App soft reset resets both cores; network soft reset only network.
// RULE_13 - App watchdog resets app core; network watchdog resets only network.
// RULE_14 - Application core can hold the network core off while running.
// RULE_15 - Network core runs independently; unused sections are powered down.
// RULE_16 - RAM sections retained per section according to power state.
// RULE_17 - Real-time counter runs in run and deep-off states.
// RULE_18 - Real-time counter produces timed events to other blocks.
// RULE_19 - Real-time counter clocked at the 32.768 kHz low-frequency rate.
// RULE_20 - Reset pin asserts asynchronously and releases synchronously.
`timescale 1ns/100ps
module dcp_power_ctrl
  import dcp_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic pin_reset_n_in,
  input wire logic supply_ok_in,
  input wire logic brownout_in,
  input wire logic comp_rise_in,
  input wire logic nfc_field_in,
  input wire logic vbus_present_in,
  input wire logic radio_event_in,
  input wire logic cpu_idle_in,
  input wire logic idle_low_power_in,
  input wire logic off_request_in,
  input wire logic [GPIO_N-1:0] gpio_in,
  input wire logic [GPIO_SEL_W-1:0] off_pin_sel_in,
  input wire logic off_pin_en_in,
  input wire logic app_soft_reset_in,
  input wire logic net_soft_reset_in,
  input wire logic app_wdog_timeout_in,
  input wire logic net_wdog_timeout_in,
  input wire logic net_hold_in,
  input wire logic net_release_in,
  input wire logic [PERIPH_N-1:0] periph_used_in,
  input wire logic [RAM_SECT_N-1:0] ram_retain_run_in,
  input wire logic [RAM_SECT_N-1:0] ram_retain_off_in,
  input wire logic [RTC_W-1:0] rtc_compare_in,
  output logic [1:0] mode_out,
  output logic app_reset_out,
  output logic net_reset_out,
  output logic net_held_out,
  output logic core_power_out,
  output logic net_power_out,
  output logic const_latency_on_out,
  output logic task_abort_out,
  output logic nvm_save_ok_out,
  output logic [PERIPH_N-1:0] periph_power_out,
  output logic [RAM_SECT_N-1:0] ram_power_out,
  output logic [CAUSE_N-1:0] reset_cause_out,
  output logic rtc_tick_out,
  output logic [RTC_W-1:0] rtc_count_out,
  output logic rtc_compare_event_out,
  output logic rtc_overflow_event_out
);
  dcp_state_e state_q;
  dcp_state_e state_d;
  logic pin_meta_q;
  logic pin_sync_q;
  logic off_pin_prev_q;
  logic vbus_prev_q;
  logic sys_kind_q;
  logic sys_kind_d;
  logic [7:0] rst_cnt_q;
  logic [7:0] rst_cnt_d;
  logic [7:0] net_cnt_q;
  logic [7:0] net_cnt_d;
  logic [CAUSE_N-1:0] cause_d;
  logic net_held_d;
  logic boot_q;

  // RULE_20 - async assert, sync release
  wire pin_arst_n = reset_n_in && pin_reset_n_in;
  always_ff @(posedge ref_clk_in or negedge pin_arst_n) begin
    if (!pin_arst_n) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= pin_meta_q;
    end
  end

  // RULE_10 - pin reset restarts app core
  wire pin_reset_act = !pin_sync_q;
  wire rtc_event = rtc_compare_event_out;
  wire off_pin_now = (off_pin_sel_in < GPIO_SEL_W'(GPIO_N)) && gpio_in[off_pin_sel_in];
  // RULE_06 - selected pin edge requests deep-off
  wire off_pin_trig = off_pin_en_in && off_pin_now && !off_pin_prev_q;
  wire vbus_rise = vbus_present_in && !vbus_prev_q;
  // RULE_07 - brownout and supply override all
  wire force_reset = !supply_ok_in || brownout_in || pin_reset_act;
  wire running = (state_q == ST_RUN) || (state_q == ST_IDLE);
  wire app_sys_reset = running && app_soft_reset_in;
  wire app_wdog_reset = running && app_wdog_timeout_in;
  // RULE_02 - deep-off wake sources
  wire off_wake = comp_rise_in || nfc_field_in || vbus_rise;
  // RULE_03 - idle wake sources
  wire idle_wake = rtc_event || radio_event_in || nfc_field_in || !cpu_idle_in;
  wire off_enter = (state_q == ST_RUN) && (off_request_in || off_pin_trig);
  wire wake_reset = (state_q == ST_OFF) && off_wake;
  wire enter_reset = force_reset || app_sys_reset || app_wdog_reset || wake_reset;
  wire rst_done = (state_q == ST_RESET) && (rst_cnt_q == CNT_ZERO);
  wire net_local = running && !app_sys_reset && !app_wdog_reset
                   && (net_soft_reset_in || net_wdog_timeout_in);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        // RULE_01 - run is the state after reset
        if (rst_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (off_enter) begin
          state_d = ST_OFF;
        end else if (cpu_idle_in) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (idle_wake) begin
          state_d = ST_RUN;
        end
      end
      ST_OFF: begin
        state_d = ST_OFF;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
    // RULE_11 - wake from deep-off goes through reset
    if (enter_reset) begin
      state_d = ST_RESET;
    end
  end

  // RULE_12 - app watchdog alone spares network reset
  assign sys_kind_d = enter_reset ? !(app_wdog_reset && !force_reset && !app_sys_reset && !wake_reset) : sys_kind_q;
  assign rst_cnt_d = enter_reset ? RST_HOLD_CYC : (rst_cnt_q != CNT_ZERO ? rst_cnt_q - 8'h01 : CNT_ZERO);
  // RULE_13 - network-only reset window
  assign net_cnt_d = net_local ? RST_HOLD_CYC : (net_cnt_q != CNT_ZERO ? net_cnt_q - 8'h01 : CNT_ZERO);

  // RULE_14 - held off by reset or program; set wins over release
  assign net_held_d = (state_d == ST_RESET) || net_hold_in || (net_held_out && !net_release_in);

  always_comb begin
    cause_d = reset_cause_out;
    if (brownout_in) begin
      cause_d = CAUSE_N'(1) << CAUSE_BROWNOUT;
    end else if (!supply_ok_in) begin
      cause_d = CAUSE_N'(1) << CAUSE_POR;
    end else if (pin_reset_act && !boot_q) begin
      cause_d = CAUSE_N'(1) << CAUSE_PIN;
    end else if (wake_reset) begin
      cause_d = CAUSE_N'(1) << CAUSE_WAKE;
    end else if (app_sys_reset) begin
      cause_d = CAUSE_N'(1) << CAUSE_SOFT;
    end else if (app_wdog_reset) begin
      cause_d = CAUSE_N'(1) << CAUSE_WDOG;
    end
  end

  wire run_d = (state_d == ST_RUN);
  wire idle_d = (state_d == ST_IDLE);
  wire off_d = (state_d == ST_OFF);
  wire rst_d = (state_d == ST_RESET);
  wire [1:0] mode_d = off_d ? MODE_OFF : (idle_d ? MODE_IDLE : (run_d ? MODE_RUN : MODE_RESET));
  // RULE_04 - idle sub-mode resources
  wire const_lat_d = run_d || (idle_d && !idle_low_power_in);
  // RULE_16 - retention by power state
  wire [RAM_SECT_N-1:0] ram_d = off_d ? ram_retain_off_in : ((run_d || idle_d) ? ram_retain_run_in : '0);
  // RULE_15 - only used sections powered
  wire [PERIPH_N-1:0] periph_d = (run_d || idle_d) ? periph_used_in : '0;

  // RULE_09 - core power, network kept off while held
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_RESET;
      rst_cnt_q <= RST_HOLD_CYC;
      net_cnt_q <= CNT_ZERO;
      sys_kind_q <= 1'b1;
      off_pin_prev_q <= 1'b0;
      vbus_prev_q <= 1'b0;
      reset_cause_out <= CAUSE_RESET_VAL;
      net_held_out <= 1'b1;
      boot_q <= 1'b1;
    end else begin
      state_q <= state_d;
      rst_cnt_q <= rst_cnt_d;
      net_cnt_q <= net_cnt_d;
      sys_kind_q <= sys_kind_d;
      off_pin_prev_q <= off_pin_now;
      vbus_prev_q <= vbus_present_in;
      reset_cause_out <= cause_d;
      net_held_out <= net_held_d;
      boot_q <= boot_q && pin_reset_act;
    end
  end

  // RULE_05 - deep-off drops core power and aborts tasks
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_out <= MODE_RESET;
      app_reset_out <= 1'b1;
      net_reset_out <= 1'b1;
      core_power_out <= 1'b1;
      net_power_out <= 1'b0;
      const_latency_on_out <= 1'b0;
      task_abort_out <= 1'b0;
      nvm_save_ok_out <= 1'b0;
      periph_power_out <= '0;
      ram_power_out <= '0;
    end else begin
      mode_out <= mode_d;
      app_reset_out <= rst_d;
      net_reset_out <= (rst_d && sys_kind_d) || (net_cnt_d != CNT_ZERO);
      core_power_out <= !off_d;
      net_power_out <= !off_d && !net_held_d;
      const_latency_on_out <= const_lat_d;
      task_abort_out <= off_enter;
      // RULE_08 - no settings save under brownout
      nvm_save_ok_out <= run_d && !brownout_in;
      periph_power_out <= periph_d;
      ram_power_out <= ram_d;
    end
  end

  // RULE_17 - counter runs outside reset, deep-off included
  wire rtc_run = (state_q != ST_RESET);

  // RULE_18 - timed counter events
  dcp_rtc_counter u_rtc (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .run_in(rtc_run),
    .compare_in(rtc_compare_in),
    .tick_out(rtc_tick_out),
    .count_out(rtc_count_out),
    .compare_event_out(rtc_compare_event_out),
    .overflow_event_out(rtc_overflow_event_out)
  );

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_brownout_reset: assert property (brownout_in |=> app_reset_out && net_reset_out && net_held_out) // RULE_07
    else $error("Brownout did not reset the system");
  a_brownout_nvm: assert property (brownout_in |=> !nvm_save_ok_out) // RULE_08
    else $error("Settings save allowed under brownout");
  a_reset_to_run: assert property ($fell(app_reset_out) |-> mode_out == MODE_RUN && net_held_out) // RULE_01
    else $error("Reset did not end in run with network held");
  a_por_start: assert property ($rose(supply_ok_in) && !brownout_in && pin_sync_q ##1 supply_ok_in [*8]
    |-> net_held_out) // RULE_09
    else $error("Network core started at power-on");
  a_off_wake: assert property (state_q == ST_OFF && nfc_field_in && supply_ok_in && !brownout_in && pin_sync_q
    |=> app_reset_out && net_held_out && reset_cause_out[CAUSE_WAKE]) // RULE_11
    else $error("Deep-off wake did not reset the system");
  a_vbus_wake: assert property (state_q == ST_OFF && $rose(vbus_present_in) |=> state_q == ST_RESET) // RULE_02
    else $error("USB supply did not leave deep-off");
  a_idle_wake: assert property (state_q == ST_IDLE && radio_event_in && !enter_reset |=> mode_out == MODE_RUN) // RULE_03
    else $error("Radio event did not wake idle");
  a_off_power: assert property (mode_out == MODE_OFF |-> !core_power_out && !net_power_out) // RULE_05
    else $error("Core powered in deep-off");
  a_off_abort: assert property (state_q == ST_RUN && off_request_in && !enter_reset
    |=> task_abort_out && mode_out == MODE_OFF) // RULE_05
    else $error("Deep-off entry did not abort tasks");
  a_net_soft: assert property (net_local && !enter_reset |=> net_reset_out && !app_reset_out) // RULE_12
    else $error("Network soft reset touched app core");
  a_app_wdog: assert property (app_wdog_reset && !force_reset && !app_sys_reset
    |=> app_reset_out && !net_reset_out && net_held_out) // RULE_13
    else $error("App watchdog reset wrong cores");
  a_net_hold: assert property (net_hold_in |=> net_held_out && !net_power_out) // RULE_14
    else $error("Network core not held off");
  a_pin_reset: assert property (!pin_reset_n_in ##1 pin_reset_n_in |=> app_reset_out) // RULE_10
    else $error("Pin reset did not reset app core");
  a_idle_submode: assert property (mode_out == MODE_IDLE && $past(idle_low_power_in) |-> !const_latency_on_out) // RULE_04
    else $error("Low-power idle kept resources on");

  c_idle_entry: cover property (mode_out == MODE_RUN ##1 mode_out == MODE_IDLE ##[1:50] mode_out == MODE_RUN);
  c_off_wake: cover property (mode_out == MODE_OFF ##[1:50] reset_cause_out[CAUSE_WAKE] && app_reset_out);
  c_net_soft: cover property (net_reset_out && !app_reset_out);
  c_brownout: cover property (reset_cause_out[CAUSE_BROWNOUT] ##[1:60] mode_out == MODE_RUN);
endmodule

// file: tb/dcp_far_side_model.sv
// Model of the supply rail, external reset pin and wake sources
`timescale 1ns/100ps
module dcp_far_side_model (
  input wire logic ref_clk_in,
  output logic pin_reset_n_out,
  output logic supply_ok_out,
  output logic brownout_out,
  output logic comp_rise_out,
  output logic nfc_field_out,
  output logic vbus_present_out
);
  initial begin
    pin_reset_n_out = 1'b1;
    supply_ok_out = 1'b1;
    brownout_out = 1'b0;
    comp_rise_out = 1'b0;
    nfc_field_out = 1'b0;
    vbus_present_out = 1'b0;
  end
  task automatic set_supply(input logic ok, input logic low);
    @(negedge ref_clk_in);
    supply_ok_out = ok;
    brownout_out = low;
  endtask
  task automatic press_pin(input int cycles);
    @(negedge ref_clk_in);
    pin_reset_n_out = 1'b0;
    repeat (cycles) @(negedge ref_clk_in);
    pin_reset_n_out = 1'b1;
  endtask
  task automatic set_wake(input logic [2:0] src);
    @(negedge ref_clk_in);
    {comp_rise_out, nfc_field_out, vbus_present_out} = src;
  endtask
endmodule

// file: tb/tb_dcp_power_ctrl.sv
// Self-checking bench for the dual-core power and reset controller
`timescale 1ns/100ps
module tb_dcp_power_ctrl;
  import dcp_pkg::*;
  logic ref_clk_in, reset_n_in, pin_n, sup_ok, bo, comp, nfc, vbus, radio, cpu_idle, idle_lp, off_req, off_en;
  logic app_soft, net_soft, app_wd, net_wd, net_hold, net_rel;
  logic app_rst, net_rst, net_held, core_pwr, net_pwr, const_lat, abort, nvm_ok, tick, cmp_ev, ovf_ev;
  logic [GPIO_N-1:0] gpio;
  logic [GPIO_SEL_W-1:0] off_sel;
  logic [RTC_W-1:0] rtc_cmp, rtc_count;
  logic [1:0] mode;
  logic [PERIPH_N-1:0] periph_pwr, periph_use;
  logic [RAM_SECT_N-1:0] ram_pwr, ram_run, ram_off;
  logic [CAUSE_N-1:0] cause;
  int fail_count = 0;
  int cmp_count = 0;

  dcp_far_side_model i_far (.ref_clk_in(ref_clk_in), .pin_reset_n_out(pin_n), .supply_ok_out(sup_ok),
    .brownout_out(bo), .comp_rise_out(comp), .nfc_field_out(nfc), .vbus_present_out(vbus));

  dcp_power_ctrl i_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .pin_reset_n_in(pin_n),
    .supply_ok_in(sup_ok), .brownout_in(bo), .comp_rise_in(comp), .nfc_field_in(nfc), .vbus_present_in(vbus),
    .radio_event_in(radio), .cpu_idle_in(cpu_idle), .idle_low_power_in(idle_lp), .off_request_in(off_req),
    .gpio_in(gpio), .off_pin_sel_in(off_sel), .off_pin_en_in(off_en), .app_soft_reset_in(app_soft),
    .net_soft_reset_in(net_soft), .app_wdog_timeout_in(app_wd), .net_wdog_timeout_in(net_wd),
    .net_hold_in(net_hold), .net_release_in(net_rel), .periph_used_in(periph_use), .ram_retain_run_in(ram_run),
    .ram_retain_off_in(ram_off), .rtc_compare_in(rtc_cmp), .mode_out(mode), .app_reset_out(app_rst),
    .net_reset_out(net_rst), .net_held_out(net_held), .core_power_out(core_pwr), .net_power_out(net_pwr),
    .const_latency_on_out(const_lat), .task_abort_out(abort), .nvm_save_ok_out(nvm_ok),
    .periph_power_out(periph_pwr), .ram_power_out(ram_pwr), .reset_cause_out(cause), .rtc_tick_out(tick),
    .rtc_count_out(rtc_count), .rtc_compare_event_out(cmp_ev), .rtc_overflow_event_out(ovf_ev));

  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_mode(input logic [1:0] m, input int limit);
    for (int i = 0; i < limit && mode !== m; i++) @(negedge ref_clk_in);
    chk("mode", 32'(m), 32'(mode));
  endtask

  task automatic release_net();
    @(negedge ref_clk_in);
    net_rel = 1'b1;
    @(negedge ref_clk_in);
    net_rel = 1'b0;
  endtask

  task automatic pulse_src(input int which);
    @(negedge ref_clk_in);
    case (which)
      0: net_soft = 1'b1;
      1: app_soft = 1'b1;
      2: net_wd = 1'b1;
      default: app_wd = 1'b1;
    endcase
    @(negedge ref_clk_in);
    {net_soft, app_soft, net_wd, app_wd} = 4'h0;
  endtask

  task automatic sc_power_on();
    wait_mode(MODE_RUN, 40);
    chk("app reset", 32'h0, 32'(app_rst));
    chk("net held", 32'h1, 32'(net_held));
    chk("cause", 32'(CAUSE_RESET_VAL), 32'(cause));
    chk("nvm ok", 32'h1, 32'(nvm_ok));
  endtask

  task automatic sc_net_hold();
    release_net();
    chk("net held", 32'h0, 32'(net_held));
    chk("net power", 32'h1, 32'(net_pwr));
    net_hold = 1'b1;
    @(negedge ref_clk_in);
    net_hold = 1'b0;
    chk("net held", 32'h1, 32'(net_held));
    chk("net power", 32'h0, 32'(net_pwr));
    chk("app reset", 32'h0, 32'(app_rst));
  endtask

  task automatic sc_soft_wdog();
    for (int k = 0; k < 2; k++) begin
      release_net();
      pulse_src(2 * k);
      chk("net reset", 32'h1, 32'(net_rst));
      chk("app reset", 32'h0, 32'(app_rst));
      repeat (25) @(negedge ref_clk_in);
      chk("net reset", 32'h0, 32'(net_rst));
      pulse_src(2 * k + 1);
      chk("app reset", 32'h1, 32'(app_rst));
      chk("net reset", 32'(k == 0), 32'(net_rst));
      chk("cause", (k == 0) ? 32'h10 : 32'h20, 32'(cause));
      wait_mode(MODE_RUN, 40);
      chk("net held", 32'h1, 32'(net_held));
    end
  endtask

  task automatic sc_idle();
    for (int k = 0; k < 2; k++) begin
      idle_lp = k[0];
      periph_use = k[0] ? 4'h5 : 4'hA;
      ram_run = k[0] ? 8'hC3 : 8'h3C;
      cpu_idle = 1'b1;
      wait_mode(MODE_IDLE, 4);
      chk("const latency", 32'(k == 0), 32'(const_lat));
      chk("ram power", 32'(ram_run), 32'(ram_pwr));
      chk("periph power", 32'(periph_use), 32'(periph_pwr));
      if (k == 0) begin
        @(negedge ref_clk_in);
        radio = 1'b1;
        @(negedge ref_clk_in);
        radio = 1'b0;
      end else begin
        i_far.set_wake(3'b010);
        @(negedge ref_clk_in);
      end
      chk("mode", 32'(MODE_RUN), 32'(mode));
      cpu_idle = 1'b0;
      i_far.set_wake(3'b000);
    end
  endtask

  task automatic sc_rtc_wake();
    logic seen;
    seen = 1'b0;
    rtc_cmp = rtc_count + 24'h000002;
    cpu_idle = 1'b1;
    wait_mode(MODE_IDLE, 4);
    for (int i = 0; i < 14000 && mode !== MODE_RUN; i++) begin
      @(negedge ref_clk_in);
      seen = seen | cmp_ev;
    end
    chk("compare event", 32'h1, 32'(seen));
    chk("mode", 32'(MODE_RUN), 32'(mode));
    cpu_idle = 1'b0;
    rtc_cmp = 24'hFFFFFF;
  endtask

  task automatic sc_off();
    logic [RTC_W-1:0] c0;
    int gap;
    for (int s = 0; s < 3; s++) begin
      off_en = (s == 2);
      off_sel = (s == 2) ? 6'h2F : 6'h05;
      ram_off = 8'h81 << s;
      @(negedge ref_clk_in);
      gpio[off_sel] = (s == 2);
      off_req = (s != 2);
      @(negedge ref_clk_in);
      gpio[off_sel] = 1'b0;
      off_req = 1'b0;
      wait_mode(MODE_OFF, 3);
      chk("abort", 32'h1, 32'(abort));
      chk("core power", 32'h0, 32'(core_pwr));
      chk("ram power", 32'(ram_off), 32'(ram_pwr));
      chk("periph power", 32'h0, 32'(periph_pwr));
      @(negedge ref_clk_in);
      chk("abort", 32'h0, 32'(abort));
      if (s == 0) begin
        c0 = rtc_count;
        for (int i = 0; i < 7000 && tick !== 1'b1; i++) @(negedge ref_clk_in);
        gap = 0;
        do begin
          @(negedge ref_clk_in);
          gap++;
        end while (tick !== 1'b1 && gap < 7000);
        chk("counter runs", 32'h1, 32'(rtc_count != c0));
        chk("tick period", 32'h1, 32'(gap >= CLK_HZ / LF_CLK_HZ && gap <= CLK_HZ / LF_CLK_HZ + 1));
      end
      i_far.set_wake(3'b100 >> s);
      @(negedge ref_clk_in);
      chk("app reset", 32'h1, 32'(app_rst));
      chk("cause", 32'h08, 32'(cause));
      i_far.set_wake(3'b000);
      wait_mode(MODE_RUN, 40);
      chk("net held", 32'h1, 32'(net_held));
    end
  endtask

  task automatic sc_supply();
    release_net();
    i_far.set_supply(1'b1, 1'b1);
    @(negedge ref_clk_in);
    chk("app reset", 32'h1, 32'(app_rst));
    chk("net reset", 32'h1, 32'(net_rst));
    chk("nvm ok", 32'h0, 32'(nvm_ok));
    chk("cause", 32'h04, 32'(cause));
    i_far.set_supply(1'b0, 1'b0);
    @(negedge ref_clk_in);
    chk("cause", 32'h01, 32'(cause));
    i_far.set_supply(1'b1, 1'b0);
    wait_mode(MODE_RUN, 40);
    chk("net held", 32'h1, 32'(net_held));
  endtask

  task automatic sc_pin();
    release_net();
    i_far.press_pin(5);
    chk("app reset", 32'h1, 32'(app_rst));
    chk("cause", 32'h02, 32'(cause));
    @(negedge ref_clk_in);
    chk("mode", 32'(MODE_RESET), 32'(mode));
    wait_mode(MODE_RUN, 40);
    chk("net held", 32'h1, 32'(net_held));
  endtask

  initial begin
    #400_000;
    fail_count++;
    wrap_up();
  end

  initial begin
    reset_n_in = 1'b0;
    {radio, cpu_idle, idle_lp, off_req, off_en, app_soft, net_soft, app_wd, net_wd, net_hold, net_rel} = '0;
    gpio = '0;
    off_sel = 6'h05;
    periph_use = 4'hA;
    ram_run = 8'h3C;
    ram_off = 8'h81;
    rtc_cmp = 24'hFFFFFF;
    repeat (16) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    sc_power_on();
    sc_net_hold();
    sc_soft_wdog();
    sc_idle();
    sc_rtc_wake();
    sc_off();
    sc_supply();
    sc_pin();
    wrap_up();
  end
endmodule
